/* File: verilog/rsc_map.vh */
// Command codes, register fields and timing counts of the command handler
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
`define RSC_OP_RECAL_HI 4'h1
`define RSC_OP_SENSE 8'h0b
`define RSC_OP_NOSENSE 8'hc3
`define RSC_ADR_CMD 3'h0
`define RSC_ADR_ERR 3'h1
`define RSC_ADR_STAT 3'h2
`define RSC_ADR_SECN 3'h3
`define RSC_ADR_CYLL 3'h4
`define RSC_ADR_CYLH 3'h5
`define RSC_ADR_CTRL 3'h6
`define RSC_ADR_CYLPOS 3'h7
`define RSC_ERR_T0 1
`define RSC_ERR_ABRT 2
`define RSC_ST_ERR 0
`define RSC_ST_SENSE 1
`define RSC_ST_SEEKDONE 4
`define RSC_ST_READY 6
`define RSC_ST_BUSY 7
`define RSC_STAT_RST 8'h40
`define RSC_STAT_BUSY 8'h80
`define RSC_FAIL_KEY 4'h4
`define RSC_FAIL_ASC 8'h02
`define RSC_CTL_SENSE_EN 0
`define RSC_CTL_W119 1
`define RSC_CTL_W120 2
`define RSC_SEEK_TIMEOUT_NS 3000
`define RSC_CLK_NS 100
`define RSC_SEEK_CYCLES (`RSC_SEEK_TIMEOUT_NS / `RSC_CLK_NS)
`define RSC_CNT_W 8
`define RSC_K_W 4
`endif

/* File: verilog/rsc_sync3.v */
// Three-stage synchroniser with agreement of the last two stages
module rsc_sync3 (
    input wire clk_sys,
    input wire rst_b,
    input wire din,
    output reg dout_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    always @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout_q <= 1'b0;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                dout_q <= s3_q;
        end
    end
endmodule // rsc_sync3

/* File: verilog/rsc_sense_store.v */
// Holder of the stored sense triple
module rsc_sense_store (
    input wire clk_sys,
    input wire rst_b,
    input wire load,
    input wire [3:0] key_in,
    input wire [7:0] asc_in,
    input wire [7:0] ascq_in,
    input wire clear,
    output reg [3:0] key_q,
    output reg [7:0] asc_q,
    output reg [7:0] ascq_q,
    output wire valid
);
    always @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            key_q <= 4'h0;
            asc_q <= 8'h00;
            ascq_q <= 8'h00;
        end
        else if (load)
        begin
            // New result replaces the old one
            key_q <= key_in;
            asc_q <= asc_in;
            ascq_q <= ascq_in;
        end
        else if (clear)
        begin
            // Cleared once reported
            key_q <= 4'h0;
            asc_q <= 8'h00;
            ascq_q <= 8'h00;
        end
    end

    assign valid = (key_q != 4'h0) || (asc_q != 8'h00) || (ascq_q != 8'h00);
endmodule // rsc_sense_store

/* File: verilog/rsc_cmd_handler.v */
// Recalibrate and sense-data request command handler
`include "rsc_map.vh"

// Overview of operation
// - Opcode 1xh recalibrates: heads are driven back to cylinder zero.
// - Failure to reach cylinder zero sets track_zero_missing, error bit 1.
// - Opcode 0Bh requests sense data; no data, no parameters used.
// - Stored sense key, code and qualifier are returned as stored.
// - With nothing stored, all three returned fields are zero.
// - Triple follows latest command; opcode C3 and queued-abort-state results never replace it.
// - A sense request clears the stored triple afterwards.
// - Any later command's result except opcode C3 or one in queued abort state replaces the stored triple.
// - Sense request behaves the same regardless of queued auto-sense.
// - Queued command error triples stay available for a sense request.
// - Aborts in queued abort state leave the stored triple unchanged.
// - Non-queued error sense data is also offered as log page 10h.
// - Status bit 1 flags sense only with both word bits 6 and data.
// - Error and sense-available bits may both be set together.
// - Status bit 1 carries no sense meaning if either word bit clear.
// - Qualifier in sector number, code in cyl low, key in cyl high 3:0.
// - Sense reporting defaults to disabled after reset.
module rsc_cmd_handler (
    input wire clk_sys,
    input wire rst_b,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    input wire ext_cmd_done,
    input wire [7:0] ext_cmd_op,
    input wire ext_cmd_queued,
    input wire [3:0] ext_key,
    input wire [7:0] ext_asc,
    input wire [7:0] ext_ascq,
    input wire queued_abort_state,
    input wire track_zero_pin,
    output reg seek_step_q,
    output reg log_valid_q,
    output reg [3:0] log_key_q,
    output reg [7:0] log_asc_q,
    output reg [7:0] log_ascq_q
);
    localparam ST_IDLE = 2'b00;
    localparam ST_SEEK = 2'b01;
    localparam ST_DONE = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] err_q;
    reg [7:0] stat_q;
    reg [7:0] secn_q;
    reg [7:0] cyll_q;
    reg [7:0] cylh_q;
    reg [2:0] ctrl_q;
    reg [`RSC_CNT_W-1:0] seek_cnt_q;
    reg [7:0] cyl_pos_q;
    reg recal_fail_q;
    reg is_sense_q;
    wire track_zero;
    wire cmd_wr;
    wire is_recal;
    wire is_sense;
    wire sense_valid;
    wire [3:0] s_key;
    wire [7:0] s_asc;
    wire [7:0] s_ascq;
    wire ext_load;
    wire recal_load;
    wire store_load;
    wire [3:0] load_key;
    wire [7:0] load_asc;
    wire [7:0] load_ascq;
    wire sense_clear;
    wire sense_report;

    rsc_sync3 u_tz_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .din(track_zero_pin),
        .dout_q(track_zero)
    );

    assign cmd_wr = reg_wr && (reg_addr == `RSC_ADR_CMD) &&
        (state_q == ST_IDLE);
    assign is_recal = (reg_wdata[7:4] == `RSC_OP_RECAL_HI);
    assign is_sense = (reg_wdata == `RSC_OP_SENSE);

    // Results from other commands; C3 and queued-abort aborts skipped
    assign ext_load = ext_cmd_done && (ext_cmd_op != `RSC_OP_NOSENSE) &&
        !queued_abort_state;
    // Recalibrate produces its own triple: zero, or not-ready style failure
    assign recal_load = (state_q == ST_SEEK) &&
        (track_zero || (seek_cnt_q == `RSC_SEEK_CYCLES));
    assign store_load = ext_load || recal_load;
    assign load_key = ext_load ? ext_key :
        ((track_zero) ? 4'h0 : `RSC_FAIL_KEY);
    assign load_asc = ext_load ? ext_asc :
        ((track_zero) ? 8'h00 : `RSC_FAIL_ASC);
    assign load_ascq = ext_load ? ext_ascq : 8'h00;
    // Sense request clears after it has returned the triple
    assign sense_clear = (state_q == ST_DONE) && is_sense_q;

    rsc_sense_store u_store (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .load(store_load),
        .key_in(load_key),
        .asc_in(load_asc),
        .ascq_in(load_ascq),
        .clear(sense_clear),
        .key_q(s_key),
        .asc_q(s_asc),
        .ascq_q(s_ascq),
        .valid(sense_valid)
    );

    // Sense flag only when reporting on and both identify bits set
    assign sense_report = ctrl_q[`RSC_CTL_SENSE_EN] &&
        ctrl_q[`RSC_CTL_W119] && ctrl_q[`RSC_CTL_W120];

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (cmd_wr && is_recal)
                    state_d = ST_SEEK;
                else if (cmd_wr && is_sense)
                    state_d = ST_DONE;
            end
            ST_SEEK:
            begin
                if (recal_load)
                    state_d = ST_DONE;
            end
            ST_DONE:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            state_q <= ST_IDLE;
            err_q <= 8'h00;
            stat_q <= `RSC_STAT_RST;
            secn_q <= 8'h00;
            cyll_q <= 8'h00;
            cylh_q <= 8'h00;
            ctrl_q <= 3'h0;
            seek_cnt_q <= {`RSC_CNT_W{1'b0}};
            cyl_pos_q <= 8'h00;
            recal_fail_q <= 1'b0;
            is_sense_q <= 1'b0;
            seek_step_q <= 1'b0;
            log_valid_q <= 1'b0;
            log_key_q <= 4'h0;
            log_asc_q <= 8'h00;
            log_ascq_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            seek_step_q <= 1'b0;
            if (reg_wr && (reg_addr == `RSC_ADR_CTRL))
                ctrl_q <= reg_wdata[2:0];
            if (reg_wr && (reg_addr == `RSC_ADR_CYLPOS))
                cyl_pos_q <= reg_wdata;
            if (cmd_wr && (is_recal || is_sense))
            begin
                // Busy while the command runs
                stat_q <= `RSC_STAT_BUSY;
                is_sense_q <= is_sense;
                seek_cnt_q <= {`RSC_CNT_W{1'b0}};
            end
            if (state_q == ST_SEEK)
            begin
                seek_cnt_q <= seek_cnt_q + 1'b1;
                // Step on the sensor alone; position count only follows
                if (!track_zero)
                begin
                    seek_step_q <= 1'b1;
                    if (cyl_pos_q != 8'h00)
                        cyl_pos_q <= cyl_pos_q - 8'h01;
                end
                if (recal_load)
                    recal_fail_q <= !track_zero;
            end
            if (state_q == ST_DONE)
            begin
                err_q <= 8'h00;
                stat_q <= 8'h00;
                stat_q[`RSC_ST_READY] <= 1'b1;
                stat_q[`RSC_ST_SEEKDONE] <= 1'b1;
                if (is_sense_q)
                begin
                    // Triple as stored, zero when empty
                    secn_q <= s_ascq;
                    cyll_q <= s_asc;
                    cylh_q <= {4'h0, s_key};
                    // Log copy no longer guaranteed
                    log_valid_q <= 1'b0;
                end
                else
                begin
                    err_q[`RSC_ERR_T0] <= recal_fail_q;
                    stat_q[`RSC_ST_ERR] <= recal_fail_q;
                    stat_q[`RSC_ST_SENSE] <= recal_fail_q && sense_report;
                end
            end
            // Non-queued error results mirrored for the log page
            if (ext_load && !ext_cmd_queued)
            begin
                log_valid_q <= 1'b1;
                log_key_q <= ext_key;
                log_asc_q <= ext_asc;
                log_ascq_q <= ext_ascq;
            end
            else if (recal_load && !track_zero)
            begin
                log_valid_q <= 1'b1;
                log_key_q <= load_key;
                log_asc_q <= load_asc;
                log_ascq_q <= load_ascq;
            end
            if (ext_cmd_done && (state_q == ST_IDLE))
            begin
                stat_q[`RSC_ST_SENSE] <= sense_report &&
                    (ext_load ? (ext_key != 4'h0) : sense_valid);
            end
        end
    end

    always @(posedge clk_sys)
    begin
        if (!rst_b)
            reg_rdata_q <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `RSC_ADR_ERR: reg_rdata_q <= err_q;
                `RSC_ADR_STAT: reg_rdata_q <= stat_q;
                `RSC_ADR_SECN: reg_rdata_q <= secn_q;
                `RSC_ADR_CYLL: reg_rdata_q <= cyll_q;
                `RSC_ADR_CYLH: reg_rdata_q <= cylh_q;
                `RSC_ADR_CTRL: reg_rdata_q <= {5'h00, ctrl_q};
                `RSC_ADR_CYLPOS: reg_rdata_q <= cyl_pos_q;
                default: reg_rdata_q <= 8'h00;
            endcase
        end
        else
            reg_rdata_q <= 8'h00;
    end
endmodule // rsc_cmd_handler

/* File: dv/rsc_head_model.sv */
// Head position model feeding the cylinder-zero sensor
module rsc_head_model (
    input wire clk_sys,
    input wire seek_step_q,
    input wire load,
    input wire [7:0] load_cyl,
    input wire stuck,
    output wire track_zero_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [7:0] cyl_q = 8'h0;
    // A stuck head never moves and never reports cylinder zero
    assign track_zero_pin = !stuck && cyl_q == 8'h0;
    always @(posedge clk_sys)
        if (load)
            cyl_q <= load_cyl;
        else if (seek_step_q && !stuck && cyl_q != 8'h0)
            cyl_q <= cyl_q - 8'h1;
endmodule // rsc_head_model

/* File: dv/rsc_cmd_handler_sva.sv */
// Port-level assertions for the command handler
module rsc_cmd_chk (
    input wire clk_sys,
    input wire rst_b,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_q,
    input wire ext_cmd_done,
    input wire [7:0] ext_cmd_op,
    input wire ext_cmd_queued,
    input wire [3:0] ext_key,
    input wire queued_abort_state,
    input wire track_zero_pin,
    input wire seek_step_q,
    input wire log_valid_q
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [1:0] ctl_q;
    reg [1:0] word_q;
    reg [5:0] since_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Identify-word bits seen at the start of each command
    always @(posedge clk_sys)
        if (!rst_b)
        begin
            ctl_q <= 2'h0;
            word_q <= 2'h0;
            since_q <= 6'h3f;
        end
        else
        begin
            if (reg_wr && reg_addr == 3'h6)
                ctl_q <= reg_wdata[2:1];
            if (reg_wr && reg_addr == 3'h0)
                word_q <= ctl_q;
            if (reg_wr && reg_addr == 3'h0 && reg_wdata[7:4] == 4'h1)
                since_q <= 6'h0;
            else if (since_q != 6'h3f)
                since_q <= since_q + 6'h1;
        end
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata_q == 8'h0)
        else $error("read data without read strobe");
    AST_ERR_ZERO: assert property (reg_rd && reg_addr == 3'h1 |=>
        reg_rdata_q[7:3] == 5'h0 && !reg_rdata_q[0])
        else $error("error register reserved bit set");
    AST_STAT_ZERO: assert property (reg_rd && reg_addr == 3'h2 |=>
        (reg_rdata_q & 8'h2c) == 8'h0)
        else $error("fault, request or corrected bit set");
    AST_SENSE_GATE: assert property (reg_rd && reg_addr == 3'h2 &&
        word_q != 2'h3 |=> !reg_rdata_q[1])
        else $error("sense flag without both word bits");
    AST_STEP_CAUSE: assert property (seek_step_q |-> since_q <= 6'd36)
        else $error("head step outside recalibration");
    AST_STEP_AT_ZERO: assert property (track_zero_pin [*8] |-> !seek_step_q)
        else $error("head stepped while at cylinder zero");
    AST_LOG_DROP: assert property (reg_wr && reg_addr == 3'h0 &&
        reg_wdata == 8'h0b && log_valid_q |-> ##[1:4] !log_valid_q)
        else $error("log copy kept after sense request");
    AST_LOG_SET: assert property (ext_cmd_done && !ext_cmd_queued &&
        !queued_abort_state && ext_cmd_op != 8'hc3 && ext_key != 4'h0
        |-> ##[1:3] log_valid_q)
        else $error("log copy missing after command error");
    cover property (seek_step_q);
    cover property ($fell(log_valid_q));
    cover property (reg_rd && reg_addr == 3'h2 ##1 reg_rdata_q[1]);
endmodule // rsc_cmd_chk
bind rsc_cmd_handler rsc_cmd_chk u_chk (.clk_sys, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .ext_cmd_done, .ext_cmd_op,
    .ext_cmd_queued, .ext_key, .queued_abort_state, .track_zero_pin,
    .seek_step_q, .log_valid_q);

/* File: dv/rsc_cmd_handler_tb.sv */
// Self-checking bench for the recalibrate and sense command handler
module rsc_cmd_handler_tb;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; \
$display("[FAIL] %s exp %h got %h", n, e, s); end end
    reg clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg [2:0] reg_addr = 3'h0;
    reg [7:0] reg_wdata = 8'h0, ext_cmd_op = 8'h0, d;
    reg ext_cmd_done = 1'b0, ext_cmd_queued = 1'b0, queued_abort_state = 1'b0;
    reg [3:0] ext_key = 4'h0;
    reg [7:0] ext_asc = 8'h0, ext_ascq = 8'h0, hm_cyl = 8'h0;
    reg hm_load = 1'b0, hm_stuck = 1'b0;
    wire track_zero_pin, seek_step_q, log_valid_q;
    wire [7:0] reg_rdata_q, log_asc_q, log_ascq_q;
    wire [3:0] log_key_q;
    int n_errors = 0, n_checks = 0, cyc = 0;
    rsc_cmd_handler DUT (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata_q, .ext_cmd_done, .ext_cmd_op, .ext_cmd_queued,
        .ext_key, .ext_asc, .ext_ascq, .queued_abort_state, .track_zero_pin,
        .seek_step_q, .log_valid_q, .log_key_q, .log_asc_q, .log_ascq_q);
    rsc_head_model u_head (.clk_sys, .seek_step_q, .load(hm_load),
        .load_cyl(hm_cyl), .stuck(hm_stuck), .track_zero_pin);
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            print_verdict;
        end
    end
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task wr(input [2:0] a, input [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input [2:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask
    // Issue a command, then poll until busy clears
    task cmd(input [7:0] op);
        int i;
        wr(3'h0, op);
        for (i = 0; i < 50; i++)
        begin
            rd(3'h2);
            if (d[7] === 1'b0)
                break;
        end
    endtask
    task sense(input [3:0] k, input [7:0] c, input [7:0] q);
        cmd(8'h0b);
        `CHK("sense status", 8'h50, d)
        rd(3'h3);
        `CHK("qualifier", q, d)
        rd(3'h4);
        `CHK("code", c, d)
        rd(3'h5);
        `CHK("key", k, d[3:0])
    endtask
    task head(input [7:0] c, input s);
        @(posedge clk_sys);
        hm_cyl <= c;
        hm_stuck <= s;
        hm_load <= 1'b1;
        @(posedge clk_sys);
        hm_load <= 1'b0;
        // Let the sensor pass the design's synchroniser
        repeat (5) @(posedge clk_sys);
    endtask
    task ext(input [7:0] op, input qd, input ab, input [19:0] t);
        @(posedge clk_sys);
        ext_cmd_op <= op;
        ext_cmd_queued <= qd;
        queued_abort_state <= ab;
        {ext_key, ext_asc, ext_ascq} <= t;
        ext_cmd_done <= 1'b1;
        @(posedge clk_sys);
        ext_cmd_done <= 1'b0;
        queued_abort_state <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task t_reset;
        rd(3'h2);
        `CHK("reset status", 8'h40, d)
        rd(3'h6);
        `CHK("reset ctrl", 8'h00, d)
        sense(4'h0, 8'h00, 8'h00);
        $display("t_reset done");
    endtask
    task t_recal;
        head(8'h07, 1'b0);
        wr(3'h7, 8'h05);
        cmd(8'h1c);
        `CHK("ok status", 8'h50, d)
        `CHK("at zero", 1'b1, track_zero_pin)
        rd(3'h1);
        `CHK("ok error", 8'h00, d)
        rd(3'h7);
        `CHK("cyl pos", 8'h00, d)
        head(8'h09, 1'b1);
        wr(3'h6, 8'h07);
        cmd(8'h10);
        `CHK("fail status", 8'h53, d)
        rd(3'h1);
        `CHK("fail error", 8'h02, d)
        sense(4'h4, 8'h02, 8'h00);
        sense(4'h0, 8'h00, 8'h00);
        $display("t_recal done");
    endtask
    task t_ext;
        head(8'h00, 1'b0);
        ext(8'h25, 1'b0, 1'b0, 20'h31105);
        `CHK("log valid", 1'b1, log_valid_q)
        `CHK("log", 20'h31105, {log_key_q, log_asc_q, log_ascq_q})
        ext(8'hc3, 1'b0, 1'b0, 20'h5aa55);
        sense(4'h3, 8'h11, 8'h05);
        `CHK("log dropped", 1'b0, log_valid_q)
        $display("t_ext done");
    endtask
    task t_queued;
        wr(3'h6, 8'h06);
        ext(8'h61, 1'b1, 1'b0, 20'h62201);
        ext(8'h61, 1'b1, 1'b1, 20'hb4700);
        sense(4'h6, 8'h22, 8'h01);
        wr(3'h6, 8'h01);
        head(8'h09, 1'b1);
        cmd(8'h1f);
        `CHK("no sense flag", 8'h51, d)
        $display("t_queued done");
    endtask
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset;
        t_recal;
        t_ext;
        t_queued;
        print_verdict;
    end
endmodule // rsc_cmd_handler_tb
